// >>> rtl/spw_defs.svh
/*
 * constants of the parameter write handler: command codes, exception codes,
 * frame byte positions, register offsets and field positions.
 * assumes inclusion by bare name from the write handler module.
 */
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH

// ==========================================================================
// command and exception codes
`define CMD_WR_SINGLE_A   8'h06
`define CMD_WR_SINGLE_B   8'h41
`define CMD_WR_MULTI_A    8'h10
`define CMD_WR_MULTI_B    8'h43
`define EXC_FLAG          8'h80
`define EXC_BAD_CMD       8'h01
`define EXC_BAD_ADDR      8'h02
`define EXC_BAD_LEN       8'h03
`define EXC_REJECTED      8'h04

// ==========================================================================
// frame layout
`define HDR_BYTES         8'h06
`define SINGLE_DATA_POS   8'h04
`define MULTI_DATA_POS    8'h07
`define SINGLE_FRAME_LEN  8'h08
`define MULTI_OVERHEAD    8'h09
`define ECHO_TX_BYTES     4'h8
`define EXC_TX_BYTES      4'h5
`define CRC_INIT          16'hffff
`define CRC_POLY          16'ha001

// ==========================================================================
// software registers
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_DISCARD       8'h08
`define CTRL_RETAIN_BIT   0
`define CTRL_ADDR_LSB     8
`define SLAVE_ADDR_RST    8'h01

`endif

// >>> rtl/spw_pkg.sv
/*
 * types of the parameter write handler: state encoding and state record.
 * assumes spw_defs.svh is on the include path.
 */
package spw_pkg;

    // ======================================================================
    // sequencer states, gray along receive, check, fetch, gather, eval
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RECV   = 3'h1,
        ST_CHECK  = 3'h3,
        ST_FETCH  = 3'h2,
        ST_GATHER = 3'h6,
        ST_EVAL   = 3'h7,
        ST_REPLY  = 3'h5
    } seq_state_t;

    typedef struct packed {
        seq_state_t      st;
        logic [5:0][7:0] hdr;
        logic [7:0]      lenByte;
        logic [7:0]      byteCnt;
        logic [15:0]     crc;
        logic [7:0]      loByte;
        logic [7:0]      entryIdx;
        logic [7:0]      nEnt;
        logic            wide;
        logic            wordSel;
        logic [31:0]     acc;
        logic            pass;
        logic            failed;
        logic [7:0]      failIdx;
        logic            ctrlClass;
        logic [7:0]      excCode;
        logic [3:0]      txIdx;
        logic [15:0]     txCrc;
        logic            txValid;
        logic [7:0]      txData;
        logic            commitValid;
        logic [15:0]     commitIdx;
        logic [31:0]     commitData;
        logic            commitRetain;
        logic [15:0]     attrIdx;
        logic            retainSel;
        logic [7:0]      slaveAddr;
        logic [31:0]     rdData;
        logic [15:0]     okCnt;
        logic [7:0]      lastExc;
        logic [15:0]     discCnt;
    } core_state_t;

endpackage : spw_pkg

// >>> rtl/frame_buf_if.sv
/*
 * carrier between the write handler and its frame word buffer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps

interface frame_buf_if #(
    parameter int WIDTH = 16,
    parameter int AW    = 7
);
    logic             wrEn;
    logic [AW-1:0]    wrAddr;
    logic [WIDTH-1:0] wrData;
    logic [AW-1:0]    rdAddr;
    logic [WIDTH-1:0] rdData;

    modport ctl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : frame_buf_if

// >>> rtl/frame_buf.sv
/*
 * word buffer holding the data field of one received frame.
 * assumes one write and one read per cycle; read data registered.
 */
`timescale 1ns/10ps

module frame_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic  mclk,
    frame_buf_if.mem   port
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdData_q;

    always_ff @(posedge mclk) begin
        if (port.wrEn) begin
            mem[port.wrAddr] <= port.wrData;
        end
        rdData_q <= mem[port.rdAddr];
    end

    assign port.rdData = rdData_q;
endmodule : frame_buf

// >>> rtl/serial_param_write_handler.sv
/*
 * slave-side handling of single and multiple parameter write frames,
 * with exception answers, commit policy and a small software register set.
 * assumes byte-wide receive and transmit streams synchronous to mclk and
 * a parameter attribute lookup that answers one cycle after attrIdx.
 */
// Implementation choices: strobed register access and the placing of the registers.
// Notes on behaviour
// - 0x06 and 0x41 write exactly one 16-bit parameter, never 32-bit mode
// - single write with address msb set answers illegal address exception
// - 16-bit write to signed parameter sign-extends upper half
// - commit only when value in range and parameter changeable
// - in 16-bit writes unsigned parameters get zero upper half, upper bits ignored
// - 0x10 and 0x43 write several parameters in 16 or 32-bit mode
// - in 32-bit mode each value is one 32-bit unit
// - start address msb selects 32-bit mode; answer echoes it
// - 32-bit mode register count is twice the parameter count
// - good multi write echoes address, command, start, count, check code
// - failed write answers with exception frame instead of echo
// - 32-bit mode accepts any in-range value of a changeable parameter
// - function parameters: any bad entry means nothing is written
// - control parameters: entries before first bad one are kept
// - retention select decides power-loss keeping for 0x06 and 0x10
// - signed class is two's complement, unsigned class compares unsigned
// - check code is crc16, init all ones, poly 0xa001, low byte first
`timescale 1ns/10ps
`include "spw_defs.svh"

module serial_param_write_handler #(
    parameter int BUF_DEPTH = 128,
    parameter int BUF_AW    = 7
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxByte,
    input  wire logic        rxEnd,
    output logic             txValid,
    output logic [7:0]       txData,
    input  wire logic        txReady,
    output logic [15:0]      attrIdx,
    input  wire logic        attrSigned,
    input  wire logic        attrWritable,
    input  wire logic        attrControl,
    input  wire logic [31:0] attrMin,
    input  wire logic [31:0] attrMax,
    output logic             commitValid,
    output logic [15:0]      commitIdx,
    output logic [31:0]      commitData,
    output logic             commitRetain,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdData
);
    import spw_pkg::*;

    spw_pkg::core_state_t s_q;
    spw_pkg::core_state_t s_d;

    frame_buf_if #(.WIDTH(16), .AW(BUF_AW)) bufPort ();

    frame_buf #(.WIDTH(16), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf (
        .mclk (mclk),
        .port (bufPort.mem)
    );

    // ======================================================================
    // crc step, reflected, one byte
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    // ======================================================================
    // combinational next state
    logic              isSingle;
    logic              isMulti;
    logic [7:0]        dataPos;
    logic [7:0]        dOff;
    logic              wEn;
    logic [BUF_AW-1:0] wAddr;
    logic [15:0]       wData;
    logic [BUF_AW-1:0] rAddr;
    logic [15:0]       regCount;
    logic [31:0]       val;
    logic              inRange;
    logic              entryOk;
    logic              commitNow;
    logic              lastEntry;
    logic [7:0]        txByte;
    logic [3:0]        txLen;

    always_comb begin
        s_d       = s_q;
        isSingle  = (s_q.hdr[1] == `CMD_WR_SINGLE_A) || (s_q.hdr[1] == `CMD_WR_SINGLE_B);
        isMulti   = (s_q.hdr[1] == `CMD_WR_MULTI_A) || (s_q.hdr[1] == `CMD_WR_MULTI_B);
        dataPos   = isSingle ? `SINGLE_DATA_POS : `MULTI_DATA_POS;
        dOff      = s_q.byteCnt - dataPos;
        wEn       = 1'b0;
        wAddr     = dOff[BUF_AW:1];
        wData     = {s_q.loByte, rxByte};
        rAddr     = s_q.wide ? BUF_AW'({s_q.entryIdx, s_q.wordSel}) : BUF_AW'(s_q.entryIdx);
        regCount  = {s_q.hdr[4], s_q.hdr[5]};
        val       = 32'h0;
        inRange   = 1'b0;
        entryOk   = 1'b0;
        commitNow = 1'b0;
        lastEntry = (s_q.entryIdx + 8'h01) == s_q.nEnt;
        txByte    = 8'h00;
        txLen     = (s_q.excCode != 8'h00) ? `EXC_TX_BYTES : `ECHO_TX_BYTES;

        s_d.commitValid = 1'b0;
        s_d.rdData      = 32'h0;

        // software register port
        if (regWr && regAddr == `REG_CTRL) begin
            s_d.retainSel = regWrData[`CTRL_RETAIN_BIT];
            s_d.slaveAddr = regWrData[`CTRL_ADDR_LSB +: 8];
        end
        if (regRd) begin
            if (regAddr == `REG_CTRL) begin
                s_d.rdData = {16'h0, s_q.slaveAddr, 7'h0, s_q.retainSel};
            end else if (regAddr == `REG_STATUS) begin
                s_d.rdData = {s_q.okCnt, 8'h0, s_q.lastExc};
            end else if (regAddr == `REG_DISCARD) begin
                s_d.rdData = {16'h0, s_q.discCnt};
            end else begin
                s_d.rdData = 32'h0;
            end
        end

        case (s_q.st)
            ST_IDLE, ST_RECV: begin
                if (rxValid) begin
                    s_d.st      = ST_RECV;
                    s_d.crc     = crc_step(s_q.st == ST_IDLE ? `CRC_INIT : s_q.crc, rxByte);
                    s_d.byteCnt = (s_q.st == ST_IDLE) ? 8'h01
                                : (s_q.byteCnt == 8'hff ? 8'hff : s_q.byteCnt + 8'h01);
                    if (s_q.st == ST_IDLE) begin
                        s_d.hdr[0] = rxByte;
                    end else if (s_q.byteCnt < `HDR_BYTES) begin
                        s_d.hdr[s_q.byteCnt[2:0]] = rxByte;
                    end else if (isMulti && s_q.byteCnt == `HDR_BYTES) begin
                        s_d.lenByte = rxByte;
                    end
                    // data words stored consecutively, high byte first
                    if (s_q.st == ST_RECV && s_q.byteCnt >= dataPos) begin
                        if (!dOff[0]) begin
                            s_d.loByte = rxByte;
                        end else if (int'(dOff[7:1]) < BUF_DEPTH) begin
                            wEn = 1'b1;
                        end
                    end
                end
                if (rxEnd && s_q.st == ST_RECV) begin
                    s_d.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                s_d.entryIdx = 8'h00;
                s_d.wordSel  = 1'b0;
                s_d.pass     = 1'b0;
                s_d.failed   = 1'b0;
                s_d.excCode  = 8'h00;
                s_d.txIdx    = 4'h0;
                s_d.txCrc    = `CRC_INIT;
                s_d.wide     = s_q.hdr[2][7];
                s_d.nEnt     = s_q.hdr[2][7] ? regCount[8:1] : regCount[7:0];
                // silent discard of corrupt or foreign frames
                if (s_q.crc != 16'h0000 || s_q.byteCnt < `SINGLE_FRAME_LEN
                    || s_q.hdr[0] != s_q.slaveAddr) begin
                    s_d.st      = ST_IDLE;
                    s_d.discCnt = s_q.discCnt + 16'h0001;
                end else if (isSingle) begin
                    s_d.wide = 1'b0;
                    s_d.nEnt = 8'h01;
                    if (s_q.hdr[2][7]) begin
                        s_d.excCode = `EXC_BAD_ADDR;
                        s_d.st      = ST_REPLY;
                    end else if (s_q.byteCnt != `SINGLE_FRAME_LEN) begin
                        s_d.excCode = `EXC_BAD_LEN;
                        s_d.st      = ST_REPLY;
                    end else begin
                        s_d.st = ST_FETCH;
                    end
                end else if (isMulti) begin
                    if ({1'b0, s_q.lenByte} != {regCount[7:0], 1'b0}
                        || regCount[15:7] != 9'h0 || regCount == 16'h0
                        || (s_q.hdr[2][7] && regCount[0])
                        || s_q.byteCnt != `MULTI_OVERHEAD + s_q.lenByte) begin
                        s_d.excCode = `EXC_BAD_LEN;
                        s_d.st      = ST_REPLY;
                    end else begin
                        s_d.st = ST_FETCH;
                    end
                end else begin
                    s_d.excCode = `EXC_BAD_CMD;
                    s_d.st      = ST_REPLY;
                end
            end
            ST_FETCH: begin
                s_d.attrIdx = {1'b0, s_q.hdr[2][6:0], s_q.hdr[3]} + {8'h00, s_q.entryIdx};
                s_d.st      = ST_GATHER;
            end
            ST_GATHER: begin
                // wide mode assembles one 32-bit unit from two words
                if (!s_q.wide) begin
                    s_d.acc = {16'h0000, bufPort.rdData};
                    s_d.st  = ST_EVAL;
                end else if (!s_q.wordSel) begin
                    s_d.acc     = {bufPort.rdData, 16'h0000};
                    s_d.wordSel = 1'b1;
                    s_d.st      = ST_FETCH;
                end else begin
                    s_d.acc     = {s_q.acc[31:16], bufPort.rdData};
                    s_d.wordSel = 1'b0;
                    s_d.st      = ST_EVAL;
                end
            end
            ST_EVAL: begin
                // value forming per class and mode
                if (s_q.wide) begin
                    val = s_q.acc;
                end else if (attrSigned) begin
                    val = {{16{s_q.acc[15]}}, s_q.acc[15:0]};
                end else begin
                    val = {16'h0000, s_q.acc[15:0]};
                end
                inRange = attrSigned
                        ? ($signed(val) >= $signed(attrMin) && $signed(val) <= $signed(attrMax))
                        : (val >= attrMin && val <= attrMax);
                entryOk = inRange && attrWritable;
                if (!s_q.pass) begin
                    if (s_q.entryIdx == 8'h00) begin
                        s_d.ctrlClass = attrControl;
                    end
                    if (!entryOk && !s_q.failed) begin
                        s_d.failed  = 1'b1;
                        s_d.failIdx = s_q.entryIdx;
                    end
                end else begin
                    commitNow = !s_q.failed || (s_q.ctrlClass && s_q.entryIdx < s_q.failIdx);
                end
                if (commitNow) begin
                    s_d.commitValid  = 1'b1;
                    s_d.commitIdx    = s_q.attrIdx;
                    s_d.commitData   = val;
                    // retention only for 0x06 and 0x10
                    s_d.commitRetain = s_q.retainSel && (s_q.hdr[1] == `CMD_WR_SINGLE_A
                                                      || s_q.hdr[1] == `CMD_WR_MULTI_A);
                end
                s_d.entryIdx = s_q.entryIdx + 8'h01;
                s_d.st       = ST_FETCH;
                if (lastEntry) begin
                    s_d.entryIdx = 8'h00;
                    if (!s_q.pass && (s_d.failed && !(s_d.ctrlClass && s_d.failIdx != 8'h00))) begin
                        s_d.excCode = `EXC_REJECTED;
                        s_d.st      = ST_REPLY;
                    end else if (!s_q.pass) begin
                        s_d.pass = 1'b1;
                    end else begin
                        // failed entries turn the echo into an exception
                        s_d.excCode = s_q.failed ? `EXC_REJECTED : 8'h00;
                        s_d.st      = ST_REPLY;
                    end
                end
            end
            ST_REPLY: begin
                // echo of header or exception frame
                if (s_q.excCode != 8'h00) begin
                    case (s_q.txIdx)
                        4'h0:    txByte = s_q.hdr[0];
                        4'h1:    txByte = s_q.hdr[1] | `EXC_FLAG;
                        4'h2:    txByte = s_q.excCode;
                        4'h3:    txByte = s_q.txCrc[7:0];
                        default: txByte = s_q.txCrc[15:8];
                    endcase
                end else if (s_q.txIdx < 4'h6) begin
                    txByte = s_q.hdr[s_q.txIdx[2:0]];
                end else begin
                    txByte = s_q.txIdx[0] ? s_q.txCrc[15:8] : s_q.txCrc[7:0];
                end
                if (!s_q.txValid || txReady) begin
                    if (s_q.txIdx < txLen) begin
                        s_d.txValid = 1'b1;
                        s_d.txData  = txByte;
                        if (s_q.txIdx < txLen - 4'h2) begin
                            s_d.txCrc = crc_step(s_q.txCrc, txByte);
                        end
                        s_d.txIdx   = s_q.txIdx + 4'h1;
                    end else begin
                        s_d.txValid = 1'b0;
                        s_d.lastExc = s_q.excCode;
                        s_d.okCnt   = s_q.okCnt + {15'h0, s_q.excCode == 8'h00};
                        s_d.st      = ST_IDLE;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    assign bufPort.wrEn   = wEn;
    assign bufPort.wrAddr = wAddr;
    assign bufPort.wrData = wData;
    assign bufPort.rdAddr = rAddr;

    // ======================================================================
    // state register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q           <= '0;
            s_q.st        <= ST_IDLE;
            s_q.slaveAddr <= `SLAVE_ADDR_RST;
            s_q.crc       <= `CRC_INIT;
            s_q.txCrc     <= `CRC_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign txValid      = s_q.txValid;
    assign txData       = s_q.txData;
    assign attrIdx      = s_q.attrIdx;
    assign commitValid  = s_q.commitValid;
    assign commitIdx    = s_q.commitIdx;
    assign commitData   = s_q.commitData;
    assign commitRetain = s_q.commitRetain;
    assign regRdData    = s_q.rdData;

    // ======================================================================
    // checks
    chk_single_bad_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        s_q.st == ST_CHECK && isSingle && s_q.hdr[2][7] && s_q.crc == 16'h0
        && s_q.byteCnt >= `SINGLE_FRAME_LEN && s_q.hdr[0] == s_q.slaveAddr
        |=> s_q.st == ST_REPLY && s_q.excCode == `EXC_BAD_ADDR)
        else $error("single write with high address not refused");
    chk_sign_extend: assert property (@(posedge mclk) disable iff (sys_rst)
        commitNow && !s_q.wide && attrSigned
        |=> commitValid && commitData[31:16] == {16{commitData[15]}})
        else $error("narrow signed write not sign extended");
    chk_unsigned_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        commitNow && !s_q.wide && !attrSigned |=> commitData[31:16] == 16'h0000)
        else $error("narrow unsigned write has nonzero upper half");
    chk_commit_allowed: assert property (@(posedge mclk) disable iff (sys_rst)
        commitNow |-> attrWritable && inRange)
        else $error("commit of unchangeable or out of range value");
    chk_function_atomic: assert property (@(posedge mclk) disable iff (sys_rst)
        s_q.st == ST_EVAL && s_q.failed && !s_q.ctrlClass |-> !commitNow)
        else $error("function parameter written despite a failure");
    chk_control_prefix: assert property (@(posedge mclk) disable iff (sys_rst)
        commitNow && s_q.failed |-> s_q.entryIdx < s_q.failIdx)
        else $error("control parameter written at or after first failure");
    chk_exc_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        txValid && s_q.txIdx == 4'h2 && s_q.excCode != 8'h00 |-> txData[7])
        else $error("exception answer lacks flagged command byte");
    chk_crc_discard: assert property (@(posedge mclk) disable iff (sys_rst)
        s_q.st == ST_CHECK && s_q.crc != 16'h0 |=> s_q.st == ST_IDLE ##1 !txValid[*4])
        else $error("corrupt frame not discarded silently");
    chk_retain_select: assert property (@(posedge mclk) disable iff (sys_rst)
        commitValid && commitRetain |-> $past(s_q.retainSel)
        && (s_q.hdr[1] == `CMD_WR_SINGLE_A || s_q.hdr[1] == `CMD_WR_MULTI_A))
        else $error("retention flagged for wrong command or select");
    chk_len_mismatch: assert property (@(posedge mclk) disable iff (sys_rst)
        s_q.st == ST_CHECK && isMulti && s_q.crc == 16'h0 && s_q.hdr[0] == s_q.slaveAddr
        && s_q.byteCnt >= `SINGLE_FRAME_LEN && s_q.lenByte != {regCount[6:0], 1'b0}
        |=> s_q.excCode == `EXC_BAD_LEN)
        else $error("length byte mismatch not refused");
endmodule : serial_param_write_handler

// >>> test/spw_master.sv
/*
 * host-side model: sends request frames with check code, collects answers.
 * assumes the handler's byte-stream ports on the same clock.
 */
`timescale 1ns/10ps

module spw_master (
    input  wire logic       mclk,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output logic            rxEnd,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output logic            txReady
);
    logic [7:0] resp[$];

    initial begin
        rxValid = 1'b0;
        rxByte  = 8'h00;
        rxEnd   = 1'b0;
        txReady = 1'b0;
    end

    // ======================================================================
    // answer sink, stalls every other cycle
    always @(posedge mclk) begin
        if (txValid && txReady) resp.push_back(txData);
        txReady <= ~txReady;
    end

    // ======================================================================
    // request sender
    // check code over a byte list
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[k]) begin
            c ^= {8'h00, q[k]};
            for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16

    // fields in order, crc low byte first
    task send(input logic [7:0] f[$], input bit bad);
        logic [15:0] c;
        c = crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8] ^ {7'h00, bad});
        resp.delete();
        foreach (f[k]) begin
            @(posedge mclk);
            rxValid <= 1'b1;
            rxByte  <= f[k];
        end
        @(posedge mclk);
        rxValid <= 1'b0;
        rxByte  <= ~rxByte;
        rxEnd   <= 1'b1;
        @(posedge mclk);
        rxEnd   <= 1'b0;
    endtask : send
endmodule : spw_master

// >>> test/serial_param_write_handler_tb.sv
/*
 * self-checking bench of the parameter write handler.
 * assumes spw_master as far side and a small attribute table here.
 */
`timescale 1ns/10ps

module serial_param_write_handler_tb;
    logic        mclk, sys_rst, rxValid, rxEnd, txValid, txReady, commitValid, commitRetain;
    logic        regWr, regRd;
    logic [7:0]  rxByte, txData, regAddr;
    logic [15:0] attrIdx, commitIdx;
    logic [31:0] commitData, regWrData, regRdData, got;
    logic [31:0] cq[$];
    int          errors, nChecks, cyc;

    serial_param_write_handler dut (.mclk(mclk), .sys_rst(sys_rst), .rxValid(rxValid),
        .rxByte(rxByte), .rxEnd(rxEnd), .txValid(txValid), .txData(txData), .txReady(txReady),
        .attrIdx(attrIdx), .attrSigned(!attrIdx[6]), .attrWritable(attrIdx[7:0] != 8'h13),
        .attrControl(attrIdx[8]), .attrMin({{16{!attrIdx[6]}}, 16'h0}), .attrMax(32'h0000ffff),
        .commitValid(commitValid), .commitIdx(commitIdx), .commitData(commitData),
        .commitRetain(commitRetain), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
    spw_master host (.mclk(mclk), .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd),
        .txValid(txValid), .txData(txData), .txReady(txReady));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (commitValid === 1'b1) cq.push_back(commitData);
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    // ======================================================================
    // shared tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge mclk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(posedge mclk);
        got = regRdData;
    endtask : rd

    task frame(input logic [7:0] f[$], input bit bad, input int n);
        int i;
        cq.delete();
        host.send(f, bad);
        for (i = 0; i < 400 && !(host.resp.size() == n && txValid === 1'b0); i++)
            @(posedge mclk);
        chk("answer length", 32'(n), 32'(host.resp.size()));
        if (n > 0) chk("answer check", 32'h0, {16'h0, host.crc16(host.resp)});
    endtask : frame

    // ======================================================================
    // scenarios
    task t_single;
        frame('{8'h01, 8'h06, 8'h00, 8'h10, 8'hfe, 8'h0c}, 1'b0, 8);
        chk("commit data", 32'hfffffe0c, cq[0]);
        chk("echo value", 32'h0c, {24'h0, host.resp[5]});
        chk("retain", 32'h1, {31'h0, commitRetain});
        frame('{8'h01, 8'h41, 8'h00, 8'h40, 8'hfe, 8'h0c}, 1'b0, 8);
        chk("unsigned data", 32'h0000fe0c, cq[0]);
        chk("no retain", 32'h0, {31'h0, commitRetain});
    endtask : t_single

    task t_addr;
        frame('{8'h01, 8'h41, 8'h80, 8'h10, 8'h00, 8'h01}, 1'b0, 5);
        chk("exception cmd", 32'hc1, {24'h0, host.resp[1]});
        chk("exception code", 32'h02, {24'h0, host.resp[2]});
        chk("commits", 32'h0, 32'(cq.size()));
    endtask : t_addr

    task t_wide;
        frame('{8'h01, 8'h43, 8'h80, 8'h20, 8'h00, 8'h04, 8'h08,
                8'h00, 8'h00, 8'h12, 8'h34, 8'hff, 8'hff, 8'hff, 8'hfe}, 1'b0, 8);
        chk("echo start", 32'h80, {24'h0, host.resp[2]});
        chk("echo count", 32'h04, {24'h0, host.resp[5]});
        chk("wide value", 32'hfffffffe, cq[1]);
    endtask : t_wide

    task t_func;
        frame('{8'h01, 8'h10, 8'h00, 8'h12, 8'h00, 8'h02, 8'h04,
                8'h00, 8'h01, 8'h00, 8'h02}, 1'b0, 5);
        chk("refused code", 32'h04, {24'h0, host.resp[2]});
        chk("commits", 32'h0, 32'(cq.size()));
        frame('{8'h01, 8'h10, 8'h01, 8'h12, 8'h00, 8'h02, 8'h04,
                8'h00, 8'h01, 8'h00, 8'h02}, 1'b0, 5);
        chk("prefix commits", 32'h1, 32'(cq.size()));
        chk("prefix data", 32'h1, cq[0]);
    endtask : t_func

    task t_len;
        frame('{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h03,
                8'h00, 8'h01, 8'h00}, 1'b0, 5);
        chk("length code", 32'h03, {24'h0, host.resp[2]});
    endtask : t_len

    task t_crc;
        frame('{8'h01, 8'h06, 8'h00, 8'h10, 8'h00, 8'h05}, 1'b1, 0);
        repeat (40) @(posedge mclk);
        chk("silent", 32'h0, 32'(host.resp.size() + cq.size()));
        rd(8'h08);
        chk("discard count", 32'h1, got);
    endtask : t_crc

    task summarize;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        cyc = 0; errors = 0; nChecks = 0; sys_rst = 1'b1;
        regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWrData = 32'h0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        wr(8'h00, 32'h00000101);
        t_single; t_addr; t_wide; t_func; t_len; t_crc;
        summarize();
    end
endmodule : serial_param_write_handler_tb
